/* rtl/cpu_ctrl_pkg.sv */
// Purpose: Shared constants and types for the core control register set
// Assumes: 32-bit core words, 8-bit register port address
// Notes:   Offsets are byte addresses, one aligned word per register
package cpu_ctrl_pkg;

    localparam int XLEN        = 32;
    localparam int ACC_W       = 64;
    localparam int ADDR_W      = 8;
    localparam int VEC_IDX_W   = 8;

    // Register port offsets
    localparam logic [ADDR_W-1:0] OFS_INT_STACK     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_USER_STACK    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_VEC_BASE      = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PC            = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PSW           = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_BACKUP_PC     = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_BACKUP_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_FAST_VECTOR   = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_ACC_HI        = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_ACC_LO        = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_ACC_MID       = 8'h28;

    // Status word field and accumulator slices
    localparam int PSW_STACK_SEL_BIT = 20;
    localparam int ACC_HI_LSB        = 32;
    localparam int ACC_MID_LSB       = 16;
    localparam int VEC_SHIFT         = 2;

    // Reset values
    localparam logic [XLEN-1:0]  RST_WORD = 32'h0000_0000;
    localparam logic [ACC_W-1:0] RST_ACC  = 64'h0000_0000_0000_0000;
    localparam logic [XLEN-1:0]  RD_IDLE  = 32'h0000_0000;

    typedef enum logic [1:0] {
        ACC_IDLE         = 2'b00,
        ACC_LOAD_PRODUCT = 2'b01,
        ACC_WRITE_HIGH   = 2'b10,
        ACC_WRITE_LOW    = 2'b11
    } acc_op_t;

    typedef struct packed {
        logic                 pc_load;
        logic [XLEN-1:0]      pc_next;
        logic                 psw_wr;
        logic [XLEN-1:0]      psw_next;
        logic                 sp_wr;
        logic [XLEN-1:0]      sp_wdata;
        logic                 fast_int;
        logic [VEC_IDX_W-1:0] vec_index;
        acc_op_t              acc_op;
        logic [ACC_W-1:0]     acc_product;
        logic [XLEN-1:0]      acc_word;
    } core_req_t;

    typedef struct packed {
        logic [XLEN-1:0] interrupt_stack_pointer;
        logic [XLEN-1:0] user_stack_pointer;
        logic [XLEN-1:0] vector_table_base;
        logic [XLEN-1:0] pc;
        logic [XLEN-1:0] processor_status_word;
        logic [XLEN-1:0] backup_program_counter;
        logic [XLEN-1:0] backup_status_word;
        logic [XLEN-1:0] fast_interrupt_vector;
        logic [XLEN-1:0] sp_view;
        logic [XLEN-1:0] vec_addr;
        logic [XLEN-1:0] rdata;
    } ctrl_state_t;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic [XLEN-1:0]  hi;
        logic [XLEN-1:0]  mid;
    } acc_state_t;

endpackage

/* rtl/reset_sync.sv */
// Purpose: Release of the asynchronous reset through two flip-flops
// Assumes: Reset pin is asynchronous to core_clk_in
// Notes:   Assertion is immediate, release takes two edges
`timescale 1ns/1ps
module reset_sync (
    input  wire logic core_clk_in,
    input  wire logic arst_n_in,
    output logic      rst_n_out
);
    typedef struct packed {
        logic meta;
        logic sync;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    always_comb begin
        st_d.meta = 1'b1;
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rst_n_out = st_q.sync;
endmodule // reset_sync

/* rtl/dsp_accumulator.sv */
// Purpose: 64-bit DSP accumulator with word slices
// Assumes: One operation per cycle, chosen upstream
// Notes:   Read slices are registered from the next value
`timescale 1ns/1ps
module dsp_accumulator
    import cpu_ctrl_pkg::*;
(
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             clk_en_in,
    input  acc_op_t               op_in,
    input  wire logic [ACC_W-1:0] product_in,
    input  wire logic [XLEN-1:0]  word_in,
    output logic      [XLEN-1:0]  high_read_out,
    output logic      [XLEN-1:0]  mid_read_out
);
    acc_state_t st_q;
    acc_state_t st_d;

    always_comb begin
        st_d = st_q;
        case (op_in)
            ACC_LOAD_PRODUCT: st_d.acc = product_in;
            ACC_WRITE_HIGH:   st_d.acc[ACC_W-1:ACC_HI_LSB] = word_in;
            ACC_WRITE_LOW:    st_d.acc[ACC_HI_LSB-1:0] = word_in;
            default:          st_d.acc = st_q.acc;
        endcase
        st_d.hi  = st_d.acc[ACC_W-1:ACC_HI_LSB];
        st_d.mid = st_d.acc[ACC_MID_LSB+XLEN-1:ACC_MID_LSB];
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '{acc: RST_ACC, hi: RST_WORD, mid: RST_WORD};
        end else if (clk_en_in) begin
            st_q <= st_d;
        end
    end

    assign high_read_out = st_q.hi;
    assign mid_read_out  = st_q.mid;

    a_acc_low_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        clk_en_in && op_in == ACC_WRITE_LOW |=> st_q.acc[31:0] == $past(word_in)
            && st_q.hi == $past(st_q.hi))
        else $error("low write did not land in bits 31 to 0");
    a_acc_mid_slice: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        st_q.mid == st_q.acc[47:16] && st_q.hi == st_q.acc[63:32])
        else $error("accumulator read slices disagree with accumulator");
endmodule // dsp_accumulator

/* rtl/cpu_ctrl_regs.sv */
// Purpose: Core control registers: stack pointers, vector base, PC,
//          status word, fast interrupt backups and DSP accumulator
// Assumes: Core request port is on core_clk_in; no synchronisers needed
// Notes:   Core updates win over register port writes in the same cycle
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module cpu_ctrl_regs
    import cpu_ctrl_pkg::*;
(
    input  wire logic              core_clk_in,
    input  wire logic              arst_n_in,
    input  wire logic              clk_en_in,
    input  wire logic [ADDR_W-1:0] bus_addr_in,
    input  wire logic [XLEN-1:0]   bus_wdata_in,
    input  wire logic              bus_wr_in,
    input  wire logic              bus_rd_in,
    output logic      [XLEN-1:0]   bus_rdata_out,
    input  core_req_t              core_req_in,
    output logic      [XLEN-1:0]   general_register_zero_out,
    output logic      [XLEN-1:0]   program_counter_out,
    output logic      [XLEN-1:0]   processor_status_word_out,
    output logic      [XLEN-1:0]   vector_table_base_out,
    output logic      [XLEN-1:0]   vector_addr_out,
    output logic      [XLEN-1:0]   acc_high_read_out,
    output logic      [XLEN-1:0]   acc_mid_read_out
);
    logic        rst_n;
    ctrl_state_t st_q;
    ctrl_state_t st_d;
    acc_op_t     acc_op;
    logic [XLEN-1:0] acc_word;
    logic [XLEN-1:0] acc_hi;
    logic [XLEN-1:0] acc_mid;
    logic        user_sel;
    logic        wr_hit;

    reset_sync u_reset_sync (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .rst_n_out   (rst_n)
    );

    assign user_sel = st_q.processor_status_word[PSW_STACK_SEL_BIT];

    // Core accumulator work wins; an idle cycle lets the port write a half
    always_comb begin
        acc_op   = core_req_in.acc_op;
        acc_word = core_req_in.acc_word;
        wr_hit   = bus_wr_in && core_req_in.acc_op == ACC_IDLE;
        if (wr_hit && bus_addr_in == OFS_ACC_HI) begin
            acc_op   = ACC_WRITE_HIGH;
            acc_word = bus_wdata_in;
        end else if (wr_hit && bus_addr_in == OFS_ACC_LO) begin
            acc_op   = ACC_WRITE_LOW;
            acc_word = bus_wdata_in;
        end
    end

    dsp_accumulator u_dsp_accumulator (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n),
        .clk_en_in     (clk_en_in),
        .op_in         (acc_op),
        .product_in    (core_req_in.acc_product),
        .word_in       (acc_word),
        .high_read_out (acc_hi),
        .mid_read_out  (acc_mid)
    );

    always_comb begin
        st_d = st_q;

        // Register port writes first, so core traffic below overrides them
        if (bus_wr_in) begin
            if (bus_addr_in == OFS_INT_STACK) begin
                st_d.interrupt_stack_pointer = bus_wdata_in;
            end else if (bus_addr_in == OFS_USER_STACK) begin
                st_d.user_stack_pointer = bus_wdata_in;
            end else if (bus_addr_in == OFS_VEC_BASE) begin
                st_d.vector_table_base = bus_wdata_in;
            end else if (bus_addr_in == OFS_PC) begin
                st_d.pc = bus_wdata_in;
            end else if (bus_addr_in == OFS_PSW) begin
                st_d.processor_status_word = bus_wdata_in;
            end else if (bus_addr_in == OFS_BACKUP_PC) begin
                st_d.backup_program_counter = bus_wdata_in;
            end else if (bus_addr_in == OFS_BACKUP_STATUS) begin
                st_d.backup_status_word = bus_wdata_in;
            end else if (bus_addr_in == OFS_FAST_VECTOR) begin
                st_d.fast_interrupt_vector = bus_wdata_in;
            end
        end

        // Register zero writes land in whichever pointer is active
        if (core_req_in.sp_wr) begin
            if (user_sel) begin
                st_d.user_stack_pointer = core_req_in.sp_wdata;
            end else begin
                st_d.interrupt_stack_pointer = core_req_in.sp_wdata;
            end
        end

        if (core_req_in.psw_wr) begin
            st_d.processor_status_word = core_req_in.psw_next;
        end

        if (core_req_in.pc_load) begin
            st_d.pc = core_req_in.pc_next;
        end

        // Fast entry: both saves and the branch in one edge
        if (core_req_in.fast_int) begin
            st_d.backup_program_counter = st_q.pc;
            st_d.backup_status_word     = st_q.processor_status_word;
            st_d.pc                     = st_q.fast_interrupt_vector;
        end

        // Registered view tracks the selector after this edge
        if (st_d.processor_status_word[PSW_STACK_SEL_BIT]) begin
            st_d.sp_view = st_d.user_stack_pointer;
        end else begin
            st_d.sp_view = st_d.interrupt_stack_pointer;
        end

        // Vector slot address from the current base
        st_d.vec_addr = st_q.vector_table_base
            + XLEN'({core_req_in.vec_index, {VEC_SHIFT{1'b0}}});

        // Read data valid in the following cycle only
        st_d.rdata = RD_IDLE;
        if (bus_rd_in) begin
            if (bus_addr_in == OFS_INT_STACK) begin
                st_d.rdata = st_q.interrupt_stack_pointer;
            end else if (bus_addr_in == OFS_USER_STACK) begin
                st_d.rdata = st_q.user_stack_pointer;
            end else if (bus_addr_in == OFS_VEC_BASE) begin
                st_d.rdata = st_q.vector_table_base;
            end else if (bus_addr_in == OFS_PC) begin
                st_d.rdata = st_q.pc;
            end else if (bus_addr_in == OFS_PSW) begin
                st_d.rdata = st_q.processor_status_word;
            end else if (bus_addr_in == OFS_BACKUP_PC) begin
                st_d.rdata = st_q.backup_program_counter;
            end else if (bus_addr_in == OFS_BACKUP_STATUS) begin
                st_d.rdata = st_q.backup_status_word;
            end else if (bus_addr_in == OFS_FAST_VECTOR) begin
                st_d.rdata = st_q.fast_interrupt_vector;
            end else if (bus_addr_in == OFS_ACC_HI) begin
                st_d.rdata = acc_hi;
            end else if (bus_addr_in == OFS_ACC_MID) begin
                st_d.rdata = acc_mid;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{default: RST_WORD};
        end else if (clk_en_in) begin
            st_q <= st_d;
        end
    end

    assign bus_rdata_out             = st_q.rdata;
    assign general_register_zero_out = st_q.sp_view;
    assign program_counter_out       = st_q.pc;
    assign processor_status_word_out = st_q.processor_status_word;
    assign vector_table_base_out     = st_q.vector_table_base;
    assign vector_addr_out           = st_q.vec_addr;
    assign acc_high_read_out         = acc_hi;
    assign acc_mid_read_out          = acc_mid;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n);

    property p_fast_entry;
        clk_en_in && core_req_in.fast_int |=>
            st_q.pc == $past(st_q.fast_interrupt_vector)
            && st_q.backup_program_counter == $past(st_q.pc);
    endproperty

    a_fast_branch_pc: assert property (p_fast_entry)
        else $error("fast entry did not branch and save PC together");
    a_fast_save_status: assert property (
        clk_en_in && core_req_in.fast_int |=>
            st_q.backup_status_word == $past(st_q.processor_status_word))
        else $error("fast entry did not save status word");
    a_backup_layout: assert property (
        clk_en_in && core_req_in.fast_int |=>
            st_q.backup_status_word[PSW_STACK_SEL_BIT] == $past(user_sel))
        else $error("backup status stack bit moved");
    a_stack_view_sel: assert property (
        st_q.sp_view == (user_sel ? st_q.user_stack_pointer
                                  : st_q.interrupt_stack_pointer))
        else $error("register zero shows wrong stack pointer");
    a_user_sp_write: assert property (
        clk_en_in && core_req_in.sp_wr && user_sel |=>
            st_q.user_stack_pointer == $past(core_req_in.sp_wdata)
            && st_q.interrupt_stack_pointer == $past(st_q.interrupt_stack_pointer))
        else $error("register zero write missed user pointer");
    // Port idle here, so a same-cycle port write cannot move the other pointer
    a_int_sp_write: assert property (
        clk_en_in && core_req_in.sp_wr && !user_sel && !bus_wr_in |=>
            st_q.interrupt_stack_pointer == $past(core_req_in.sp_wdata)
            && st_q.user_stack_pointer == $past(st_q.user_stack_pointer))
        else $error("register zero write missed interrupt pointer");
    a_base_port_write: assert property (
        clk_en_in && bus_wr_in && bus_addr_in == OFS_VEC_BASE |=>
            vector_table_base_out == $past(bus_wdata_in))
        else $error("vector base write lost");
    a_fast_over_load: assert property (
        clk_en_in && core_req_in.fast_int && core_req_in.pc_load |=>
            st_q.pc == $past(st_q.fast_interrupt_vector))
        else $error("PC load beat the fast vector");
    a_pc_follow: assert property (
        clk_en_in && core_req_in.pc_load && !core_req_in.fast_int |=>
            st_q.pc == $past(core_req_in.pc_next))
        else $error("PC did not follow executing instruction");
    a_status_update: assert property (
        clk_en_in && core_req_in.psw_wr |=>
            st_q.processor_status_word == $past(core_req_in.psw_next))
        else $error("status word missed instruction result");
    a_vector_locate: assert property (
        clk_en_in |=> st_q.vec_addr == $past(st_q.vector_table_base)
            + {22'h000000, $past(core_req_in.vec_index), 2'b00})
        else $error("vector address not from table base");
    a_product_load: assert property (
        clk_en_in && core_req_in.acc_op == ACC_LOAD_PRODUCT |=>
            acc_hi == $past(core_req_in.acc_product[63:32]))
        else $error("multiply did not overwrite accumulator");
    a_high_write: assert property (
        clk_en_in && core_req_in.acc_op == ACC_WRITE_HIGH |=>
            acc_hi == $past(core_req_in.acc_word)
            && acc_mid[31:16] == $past(core_req_in.acc_word[15:0]))
        else $error("high write did not land in bits 63 to 32");
    a_read_one_cycle: assert property (
        clk_en_in && !bus_rd_in |=> bus_rdata_out == RD_IDLE)
        else $error("read data outside its cycle");
    a_freeze_hold: assert property (
        !clk_en_in |=> $stable(st_q))
        else $error("state moved while clock enable low");
    a_busy_acc_port: assert property (
        clk_en_in && core_req_in.acc_op == ACC_LOAD_PRODUCT && bus_wr_in |=>
            acc_mid == $past(core_req_in.acc_product[47:16]))
        else $error("port write disturbed a multiply result");
    a_port_high_write: assert property (
        clk_en_in && wr_hit && bus_addr_in == OFS_ACC_HI |=>
            acc_hi == $past(bus_wdata_in))
        else $error("port high write did not land");
    a_mid_readback: assert property (
        clk_en_in && bus_rd_in && bus_addr_in == OFS_ACC_MID |=>
            bus_rdata_out == $past(acc_mid))
        else $error("middle read returned wrong slice");

    c_fast_entry: cover property (clk_en_in && core_req_in.fast_int);
    c_user_stack: cover property (clk_en_in && core_req_in.sp_wr && user_sel);
    c_mac_then_mid: cover property (
        clk_en_in && core_req_in.acc_op == ACC_LOAD_PRODUCT ##1 bus_rd_in
            && bus_addr_in == OFS_ACC_MID);
    c_port_high_write: cover property (
        clk_en_in && bus_wr_in && bus_addr_in == OFS_ACC_HI && wr_hit);
    c_frozen_write: cover property (!clk_en_in && bus_wr_in);
endmodule // cpu_ctrl_regs

/* tb/core_model.sv */
// Purpose: Behavioural model of the core execution and interrupt logic
// Assumes: Same clock as the register set; requests change after rising edges
// Notes:   Each request is a one-cycle pulse, then the port returns to idle
`timescale 1ns/1ps
module core_model
    import cpu_ctrl_pkg::*;
(
    input  wire logic core_clk_in,
    output core_req_t core_req_out
);

    initial core_req_out = '0;

    // Ends just after the taking edge so the caller can sample its effect
    task automatic issue(input core_req_t req);
        @(posedge core_clk_in);
        core_req_out <= req;
        @(posedge core_clk_in);
        core_req_out <= '0;
    endtask

    task automatic write_sp(input logic [XLEN-1:0] val);
        core_req_t r;
        r = '0;
        r.sp_wr = 1'b1;
        r.sp_wdata = {val[XLEN-1:2], 2'b00};
        issue(r);
    endtask

endmodule // core_model

/* tb/cpu_control_and_accumulator_regs_tb.sv */
// Purpose: Self-checking bench for the core control register set
// Assumes: Register port and core port share the 50 MHz core clock
// Notes:   Clock enable dropped once to check that a write is frozen out
`timescale 1ns/1ps
module cpu_control_and_accumulator_regs_tb;
    import cpu_ctrl_pkg::*;

    logic              core_clk;
    logic              arst_n;
    logic              clk_en;
    logic [ADDR_W-1:0] bus_addr;
    logic [XLEN-1:0]   bus_wdata;
    logic              bus_wr;
    logic              bus_rd;
    logic [XLEN-1:0]   bus_rdata;
    core_req_t         core_req;
    logic [XLEN-1:0]   gr0;
    logic [XLEN-1:0]   pc;
    logic [XLEN-1:0]   processor_status_word;
    logic [XLEN-1:0]   vtb;
    logic [XLEN-1:0]   vaddr;
    logic [XLEN-1:0]   acc_hi;
    logic [XLEN-1:0]   acc_mid;
    int                failures;
    int                num_checks;

    core_model u_core (.core_clk_in(core_clk), .core_req_out(core_req));

    cpu_ctrl_regs dut (
        .core_clk_in(core_clk), .arst_n_in(arst_n), .clk_en_in(clk_en),
        .bus_addr_in(bus_addr), .bus_wdata_in(bus_wdata), .bus_wr_in(bus_wr),
        .bus_rd_in(bus_rd), .bus_rdata_out(bus_rdata), .core_req_in(core_req),
        .general_register_zero_out(gr0), .program_counter_out(pc),
        .processor_status_word_out(processor_status_word), .vector_table_base_out(vtb),
        .vector_addr_out(vaddr), .acc_high_read_out(acc_hi), .acc_mid_read_out(acc_mid)
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic final_report();
        $display("Checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [XLEN-1:0] got, input logic [XLEN-1:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [XLEN-1:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [XLEN-1:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    task automatic core_do(input core_req_t r);
        u_core.issue(r);
        #1;
    endtask

    task automatic test_reset();
        chk(pc, RST_WORD, "pc after reset");
        chk(gr0, RST_WORD, "stack pointer after reset");
        chk(acc_hi, RST_WORD, "accumulator after reset");
    endtask

    task automatic test_port_regs();
        logic [XLEN-1:0] d;
        core_req_t       r;
        for (int i = 0; i < 8; i++)
            bus_write(8'(i * 4), 32'h1000_0000 + 32'(i * 32'h104));
        for (int i = 0; i < 8; i++) begin
            bus_read(8'(i * 4), d);
            chk(d, 32'h1000_0000 + 32'(i * 32'h104), "register readback");
        end
        @(posedge core_clk);
        #1;
        chk(bus_rdata, RD_IDLE, "read data after its cycle");
        chk(vtb, 32'h1000_0208, "vector base");
        chk(gr0, 32'h1000_0000, "interrupt pointer active");
        bus_read(8'h40, d);
        chk(d, RD_IDLE, "unmapped read");
        r = '0;
        r.vec_index = 8'h05;
        core_do(r);
        chk(vaddr, 32'h1000_021C, "vector address");
    endtask

    task automatic test_stack();
        logic [XLEN-1:0] d;
        core_req_t       r;
        bus_write(OFS_INT_STACK, 32'h0000_1000);
        bus_write(OFS_USER_STACK, 32'h0000_2000);
        r = '0;
        r.psw_wr = 1'b1;
        core_do(r);
        chk(gr0, 32'h0000_1000, "select interrupt pointer");
        r.psw_next = 32'h0010_0000;
        core_do(r);
        chk(gr0, 32'h0000_2000, "select user pointer");
        chk(processor_status_word, 32'h0010_0000, "status word");
        u_core.write_sp(32'h0000_2FFC);
        #1;
        chk(gr0, 32'h0000_2FFC, "stack pointer write");
        bus_read(OFS_INT_STACK, d);
        chk(d, 32'h0000_1000, "interrupt pointer untouched");
    endtask

    task automatic test_fast_int();
        logic [XLEN-1:0] d;
        core_req_t       r;
        bus_write(OFS_FAST_VECTOR, 32'h0000_8000);
        r = '0;
        r.pc_load = 1'b1;
        r.pc_next = 32'h0000_1234;
        r.psw_wr = 1'b1;
        r.psw_next = 32'hA5A5_0F0F;
        core_do(r);
        chk(pc, 32'h0000_1234, "pc load");
        r = '0;
        r.fast_int = 1'b1;
        r.pc_load = 1'b1;
        r.pc_next = 32'h0000_5678;
        core_do(r);
        chk(pc, 32'h0000_8000, "branch to fast vector");
        chk(processor_status_word, 32'hA5A5_0F0F, "status kept");
        bus_read(OFS_BACKUP_PC, d);
        chk(d, 32'h0000_1234, "saved pc");
        bus_read(OFS_BACKUP_STATUS, d);
        chk(d, 32'hA5A5_0F0F, "saved status");
    endtask

    task automatic test_acc();
        logic [XLEN-1:0] d;
        core_req_t       r;
        r = '0;
        r.acc_op = ACC_LOAD_PRODUCT;
        r.acc_product = 64'h0123_4567_89AB_CDEF;
        core_do(r);
        chk(acc_hi, 32'h0123_4567, "product high");
        chk(acc_mid, 32'h4567_89AB, "product middle");
        r.acc_op = ACC_WRITE_HIGH;
        r.acc_word = 32'hDEAD_BEEF;
        core_do(r);
        chk(acc_mid, 32'hBEEF_89AB, "high write");
        r.acc_op = ACC_WRITE_LOW;
        r.acc_word = 32'h1111_2222;
        core_do(r);
        chk(acc_mid, 32'hBEEF_1111, "low write");
        bus_write(OFS_ACC_LO, 32'h3333_4444);
        bus_write(OFS_ACC_MID, 32'h0000_0000);
        chk(acc_mid, 32'hBEEF_3333, "port low write");
        bus_read(OFS_ACC_HI, d);
        chk(d, 32'hDEAD_BEEF, "port high read");
        bus_read(OFS_ACC_MID, d);
        chk(d, 32'hBEEF_3333, "port middle read");
        r.acc_op = ACC_LOAD_PRODUCT;
        r.acc_product = 64'hFEDC_BA98_7654_3210;
        core_do(r);
        chk(acc_hi, 32'hFEDC_BA98, "overwrite high");
        chk(acc_mid, 32'hBA98_7654, "overwrite middle");
    endtask

    // Core and port hit the same register in one cycle; core must win
    task automatic test_priority();
        core_req_t r;
        u_core.write_sp(32'h0000_0FF0);
        #1;
        chk(gr0, 32'h0000_0FF0, "interrupt pointer write");
        r = '0;
        r.pc_load = 1'b1;
        r.pc_next = 32'h0000_4000;
        fork
            bus_write(OFS_PC, 32'h0000_0BAD);
            core_do(r);
        join
        chk(pc, 32'h0000_4000, "core wins over port");
        r = '0;
        r.acc_op = ACC_LOAD_PRODUCT;
        r.acc_product = 64'h0000_1111_2222_0000;
        fork
            bus_write(OFS_ACC_LO, 32'hFFFF_FFFF);
            core_do(r);
        join
        chk(acc_mid, 32'h1111_2222, "multiply wins over port");
        bus_write(OFS_ACC_HI, 32'h8765_4321);
        chk(acc_hi, 32'h8765_4321, "port high write");
        chk(acc_mid, 32'h4321_2222, "port high write middle");
    endtask

    task automatic test_freeze();
        @(posedge core_clk);
        clk_en <= 1'b0;
        bus_addr <= OFS_VEC_BASE;
        bus_wdata <= 32'h0000_0ABC;
        bus_wr <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
        clk_en <= 1'b1;
        #1;
        chk(vtb, 32'h1000_0208, "write ignored while frozen");
        bus_write(OFS_VEC_BASE, 32'h0000_0ABC);
        chk(vtb, 32'h0000_0ABC, "write after freeze");
    endtask

    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        bus_addr = '0;
        bus_wdata = '0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        failures = 0;
        num_checks = 0;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        test_reset();
        test_port_regs();
        test_stack();
        test_fast_int();
        test_acc();
        test_priority();
        test_freeze();
        final_report();
    end

    // Whole run is about a hundred cycles; thirty times that means a hang
    initial begin
        #(20 * 3000);
        failures++;
        final_report();
    end

endmodule // cpu_control_and_accumulator_regs_tb
